// ---- inc/analog_input_scaler_consts.svh ----
`ifndef ANALOG_INPUT_SCALER_CONSTS_SVH
`define ANALOG_INPUT_SCALER_CONSTS_SVH

`define ADDR_INPUT_CHANNEL_COUNT 8'h00
`define ADDR_SCALED_RESULT_CH1 8'h04
`define ADDR_SCALED_RESULT_CH2 8'h08
`define ADDR_OFFSET_COUNT 8'h10
`define ADDR_OFFSET_CH1 8'h14
`define ADDR_OFFSET_CH2 8'h18
`define ADDR_NUMERATOR_COUNT 8'h20
`define ADDR_NUMERATOR_CH1 8'h24
`define ADDR_NUMERATOR_CH2 8'h28
`define ADDR_DENOMINATOR_COUNT 8'h30
`define ADDR_DENOMINATOR_CH1 8'h34
`define ADDR_DENOMINATOR_CH2 8'h38
`define CHANNEL_COUNT_VALUE 8'h02
`define RESET_OFFSET 16'h0000
`define RESET_NUMERATOR 16'h0001
`define RESET_DENOMINATOR 16'h0001
`define RESET_RESULT 32'h00000000
`define RAW_FULL_SCALE 10'h3FF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- inc/analog_input_scaler_pkg.sv ----
package analog_input_scaler_pkg;

    typedef struct packed {
        logic signed [15:0] offset;
        logic signed [15:0] numerator;
        logic signed [15:0] denominator;
    } channel_setting_type;

    typedef struct packed {
        logic valid;
        logic [9:0] count;
    } raw_sample_type;

endpackage

// ---- hw/analog_input_scaler.sv ----
// Overview of operation
// - Each channel adds its signed offset to the raw reading before any multiply or divide.
// - The offset-corrected reading is multiplied by the channel's signed numerator.
// - That product is divided by the channel's signed denominator and the quotient is the result; a zero denominator keeps the previous result.
// - After reset offsets are zero and numerators and denominators are one, so results show raw counts.
// - The raw reading is a 10-bit count whose full scale of 1023 stands for 3.3 V or 20 mA.
// - A read-only channel count of two is reported by the result, offset, numerator and denominator groups.
// - Each channel's scaled value is presented continuously as a signed 32-bit read-only result.
// - Offsets, numerators and denominators are signed 16-bit values that software reads and writes.
`include "analog_input_scaler_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module analog_input_scaler #(
    parameter int CHANNELS = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [9:0] raw_count_ch1,
    input wire logic [9:0] raw_count_ch2,
    input wire logic raw_valid_ch1,
    input wire logic raw_valid_ch2,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic signed [31:0] scaled_result_ch1,
    output logic signed [31:0] scaled_result_ch2
);

    analog_input_scaler_pkg::channel_setting_type setting [2];
    analog_input_scaler_pkg::raw_sample_type sample [2];
    logic signed [31:0] quotient [2];
    logic signed [31:0] next_quotient [2];
    logic [7:0] write_addr;
    logic [31:0] write_data;
    logic [3:0] write_strb;
    logic have_addr;
    logic have_data;

    // The raw samples come from converter logic on the same clock.
    assign sample[0] = '{valid: raw_valid_ch1, count: raw_count_ch1};
    assign sample[1] = '{valid: raw_valid_ch2, count: raw_count_ch2};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_channel
            wire logic signed [17:0] corrected;
            wire logic signed [33:0] product;
            wire logic signed [33:0] divided;
            wire logic zero_denominator;
            // The raw count is zero-extended, so 1023 is full scale.
            assign corrected = $signed({8'h00, sample[ch].count}) + 18'(setting[ch].offset);
            assign product = 34'(corrected) * 34'(setting[ch].numerator);
            assign zero_denominator = setting[ch].denominator == 16'sh0000;
            assign divided = zero_denominator ? 34'sh0 : product / 34'(setting[ch].denominator);
            always_comb begin
                next_quotient[ch] = quotient[ch];
                if (sample[ch].valid && !zero_denominator) begin
                    next_quotient[ch] = divided[31:0];
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    quotient[ch] <= `RESET_RESULT;
                end else begin
                    quotient[ch] <= next_quotient[ch];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scaled_result_ch1 <= `RESET_RESULT;
            scaled_result_ch2 <= `RESET_RESULT;
        end else begin
            scaled_result_ch1 <= next_quotient[0];
            scaled_result_ch2 <= next_quotient[1];
        end
    end

    // Write channel: address and data are latched independently.
    wire logic take_aw = s_axi_awvalid && s_axi_awready;
    wire logic take_w = s_axi_wvalid && s_axi_wready;
    wire logic [7:0] eff_waddr = take_aw ? s_axi_awaddr : write_addr;
    wire logic [31:0] eff_wdata = take_w ? s_axi_wdata : write_data;
    wire logic [3:0] eff_wstrb = take_w ? s_axi_wstrb : write_strb;
    wire logic do_write = (have_addr || take_aw) && (have_data || take_w) && !s_axi_bvalid;
    wire logic w_off1 = eff_waddr == `ADDR_OFFSET_CH1;
    wire logic w_off2 = eff_waddr == `ADDR_OFFSET_CH2;
    wire logic w_num1 = eff_waddr == `ADDR_NUMERATOR_CH1;
    wire logic w_num2 = eff_waddr == `ADDR_NUMERATOR_CH2;
    wire logic w_den1 = eff_waddr == `ADDR_DENOMINATOR_CH1;
    wire logic w_den2 = eff_waddr == `ADDR_DENOMINATOR_CH2;
    wire logic w_hit = w_off1 || w_off2 || w_num1 || w_num2 || w_den1 || w_den2;
    wire logic [15:0] wmask = {{8{eff_wstrb[1]}}, {8{eff_wstrb[0]}}};

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data, input logic [15:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            have_addr <= 1'b0;
            have_data <= 1'b0;
            write_addr <= 8'h00;
            write_data <= 32'h00000000;
            write_strb <= 4'h0;
        end else begin
            if (take_aw) begin
                write_addr <= s_axi_awaddr;
            end
            if (take_w) begin
                write_data <= s_axi_wdata;
                write_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                have_addr <= 1'b0;
                have_data <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (take_aw) begin
                    have_addr <= 1'b1;
                    s_axi_awready <= 1'b0;
                end
                if (take_w) begin
                    have_data <= 1'b1;
                    s_axi_wready <= 1'b0;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                    s_axi_awready <= 1'b1;
                    s_axi_wready <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            setting[0] <= '{`RESET_OFFSET, `RESET_NUMERATOR, `RESET_DENOMINATOR};
            setting[1] <= '{`RESET_OFFSET, `RESET_NUMERATOR, `RESET_DENOMINATOR};
        end else if (do_write) begin
            if (w_off1) setting[0].offset <= merge(setting[0].offset, eff_wdata[15:0], wmask);
            if (w_off2) setting[1].offset <= merge(setting[1].offset, eff_wdata[15:0], wmask);
            if (w_num1) setting[0].numerator <= merge(setting[0].numerator, eff_wdata[15:0], wmask);
            if (w_num2) setting[1].numerator <= merge(setting[1].numerator, eff_wdata[15:0], wmask);
            if (w_den1) setting[0].denominator <= merge(setting[0].denominator, eff_wdata[15:0], wmask);
            if (w_den2) setting[1].denominator <= merge(setting[1].denominator, eff_wdata[15:0], wmask);
        end
    end

    // Read channel: one read at a time, answered one cycle after the address.
    wire logic take_ar = s_axi_arvalid && s_axi_arready;
    wire logic is_count = s_axi_araddr == `ADDR_INPUT_CHANNEL_COUNT || s_axi_araddr == `ADDR_OFFSET_COUNT
        || s_axi_araddr == `ADDR_NUMERATOR_COUNT || s_axi_araddr == `ADDR_DENOMINATOR_COUNT;
    logic [31:0] read_value;
    logic read_hit;

    always_comb begin
        read_hit = 1'b1;
        case (s_axi_araddr)
            `ADDR_SCALED_RESULT_CH1: read_value = quotient[0];
            `ADDR_SCALED_RESULT_CH2: read_value = quotient[1];
            `ADDR_OFFSET_CH1: read_value = {{16{setting[0].offset[15]}}, setting[0].offset};
            `ADDR_OFFSET_CH2: read_value = {{16{setting[1].offset[15]}}, setting[1].offset};
            `ADDR_NUMERATOR_CH1: read_value = {{16{setting[0].numerator[15]}}, setting[0].numerator};
            `ADDR_NUMERATOR_CH2: read_value = {{16{setting[1].numerator[15]}}, setting[1].numerator};
            `ADDR_DENOMINATOR_CH1: read_value = {{16{setting[0].denominator[15]}}, setting[0].denominator};
            `ADDR_DENOMINATOR_CH2: read_value = {{16{setting[1].denominator[15]}}, setting[1].denominator};
            default: begin
                read_value = is_count ? {24'h000000, `CHANNEL_COUNT_VALUE} : 32'h00000000;
                read_hit = is_count;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (take_ar) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_value;
            s_axi_rresp <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ---- tb/analog_input_scaler_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module analog_input_scaler_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic raw_valid_ch1,
    input wire logic raw_valid_ch2,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signed [31:0] scaled_result_ch1,
    input wire logic signed [31:0] scaled_result_ch2
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_HOLD_CH1: assert property (!raw_valid_ch1 |=> $stable(scaled_result_ch1)) else $error("result 1 moved");
    AST_HOLD_CH2: assert property (!raw_valid_ch2 |=> $stable(scaled_result_ch2)) else $error("result 2 moved");
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write early");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no answer");
    AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    AST_R_BLOCKS: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready) else $error("read end");
endmodule
bind analog_input_scaler analog_input_scaler_chk i_chk (.*);
`default_nettype wire

// ---- tb/adc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [9:0] code_ch1,
    input wire logic [9:0] code_ch2,
    output logic [9:0] raw_count_ch1,
    output logic [9:0] raw_count_ch2,
    output logic raw_valid_ch1,
    output logic raw_valid_ch2
);
    // Outside a conversion the count is inverted every cycle, so nothing stale looks valid.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {raw_valid_ch1, raw_valid_ch2, raw_count_ch1, raw_count_ch2} <= 22'h000000;
        end else begin
            {raw_valid_ch1, raw_valid_ch2} <= {start, start};
            raw_count_ch1 <= start ? code_ch1 : ~raw_count_ch1;
            raw_count_ch2 <= start ? code_ch2 : ~raw_count_ch2;
        end
    end
endmodule
`default_nettype wire

// ---- tb/analog_input_scaler_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "analog_input_scaler_consts.svh"
module analog_input_scaler_tb;
    logic clk = 1'b0, reset_n = 1'b0, start = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [9:0] code1 = 10'h000, code2 = 10'h000;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    wire logic [9:0] raw1, raw2;
    wire logic rv1, rv2, awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata, res1, res2;
    int failures = 0;
    int checks = 0;
    adc_model i_adc (.clk(clk), .reset_n(reset_n), .start(start), .code_ch1(code1), .code_ch2(code2),
        .raw_count_ch1(raw1), .raw_count_ch2(raw2), .raw_valid_ch1(rv1), .raw_valid_ch2(rv2));
    analog_input_scaler i_dut (.clk(clk), .reset_n(reset_n), .raw_count_ch1(raw1), .raw_count_ch2(raw2),
        .raw_valid_ch1(rv1), .raw_valid_ch2(rv2), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .scaled_result_ch1(res1), .scaled_result_ch2(res2));
    function automatic logic [31:0] scale(input int c, input int o, input int n, input int d);
        return (c + o) * n / d;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, e});
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, d);
        chk({30'h0, rresp}, {30'h0, e});
        @(posedge clk);
    endtask
    task automatic samp(input logic [9:0] c1, input logic [9:0] c2);
        {start, code1, code2} <= {1'b1, c1, c2};
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset_values();
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 3; j++) begin
                rd(8'(i * 16 + j * 4), (j == 0) ? 32'h2 : ((i >= 2) ? 32'h1 : 32'h0), `RESP_OKAY);
            end
        end
        wr(`ADDR_DENOMINATOR_COUNT, 32'h5, `RESP_SLVERR);
        rd(`ADDR_DENOMINATOR_COUNT, 32'h2, `RESP_OKAY);
        wr(8'h40, 32'h1234, `RESP_SLVERR);
        rd(8'h40, 32'h0, `RESP_SLVERR);
    endtask
    task automatic t_scaling();
        samp(10'h3FF, 10'h064);
        chk(res1, 32'h3FF);
        chk(res2, 32'h64);
        wr(`ADDR_OFFSET_CH1, 32'hFFE9, `RESP_OKAY);
        wr(`ADDR_NUMERATOR_CH1, 32'hFFF9, `RESP_OKAY);
        wr(`ADDR_DENOMINATOR_CH1, 32'h3, `RESP_OKAY);
        wr(`ADDR_OFFSET_CH2, 32'h5, `RESP_OKAY);
        wr(`ADDR_NUMERATOR_CH2, 32'h3, `RESP_OKAY);
        wr(`ADDR_DENOMINATOR_CH2, 32'hFFFE, `RESP_OKAY);
        rd(`ADDR_OFFSET_CH1, 32'hFFFFFFE9, `RESP_OKAY);
        samp(10'h3FF, 10'h000);
        chk(res1, scale(1023, -23, -7, 3));
        chk(res2, scale(0, 5, 3, -2));
        rd(`ADDR_SCALED_RESULT_CH2, scale(0, 5, 3, -2), `RESP_OKAY);
        wr(`ADDR_DENOMINATOR_CH1, 32'h0, `RESP_OKAY);
        samp(10'h00A, 10'h00A);
        chk(res1, scale(1023, -23, -7, 3));
        chk(res2, scale(10, 5, 3, -2));
    endtask
    task automatic t_reset_again();
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        chk(res1, 32'h0);
        rd(`ADDR_OFFSET_CH1, 32'h0, `RESP_OKAY);
        rd(`ADDR_DENOMINATOR_CH1, 32'h1, `RESP_OKAY);
        samp(10'h123, 10'h045);
        chk(res1, 32'h123);
        chk(res2, 32'h45);
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #50000;
        failures++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_reset_values();
        t_scaling();
        t_reset_again();
        close_out();
    end
endmodule
`default_nettype wire
